// ---- rtl/l2ct_addr_map.sv ----
// l2ct_addr_map: splits an address into tag index, stored tag and data
// ram address for the selected cache size, and rebuilds a victim
// address from a tag read. purely combinational.
`timescale 1ns/100ps
`default_nettype none
module l2ct_addr_map
  import l2ct_pkg::*;
(
  input  wire logic [31:0]    addr_i,    // request address
  input  wire logic [1:0]     size_i,    // cache size
  input  wire logic [13:0]    mask_i,    // cast-out address mask
  input  wire logic [TAG_W-1:0] tag_i,   // tag read from tag ram
  output logic [IDX_W-1:0]    index_o,   // tag ram address
  output logic [TAG_W-1:0]    tag_o,     // tag to write
  output logic [DRA_W-1:0]    dram_o,    // data ram address
  output logic [31:0]         victim_o   // cast-out line address
);

  // first address bit of the stored tag
  function automatic logic [4:0] tag_lsb(input logic [1:0] s);
    unique case (s)
      SIZE_512K: tag_lsb = TLSB_512K;
      SIZE_1M:   tag_lsb = TLSB_1M;
      default:   tag_lsb = TLSB_256K;
    endcase
  endfunction

  logic [4:0] lsb;

  // ----------------------------------------------------------------
  // field split
  // ----------------------------------------------------------------
  // narrower tag rams serve a smaller space by masking the top bits
  always_comb
  begin
    lsb      = tag_lsb(size_i);
    tag_o    = TAG_W'(addr_i >> lsb) & ~mask_i;
    index_o  = IDX_W'(addr_i >> LINE_LSB)
             & ~(IDX_W'({IDX_W{1'b1}}) << (lsb - LINE_LSB));
    dram_o   = DRA_W'(addr_i >> DRA_LSB)
             & ~(DRA_W'({DRA_W{1'b1}}) << (lsb - DRA_LSB));
    victim_o = (32'(tag_i & ~mask_i) << lsb)
             | (32'(index_o) << LINE_LSB);
  end

endmodule
`default_nettype wire

// ---- rtl/l2ct_ctrl.sv ----
// l2ct_ctrl: level-2 cache controller towards external tag ram and
// burst or asynchronous data sram. assumes a request source that holds
// req_valid_i until req_ready_o, and tag ram answers within one cycle.
`timescale 1ns/100ps
`default_nettype none
module l2ct_ctrl
  import l2ct_pkg::*;
(
  input  wire logic           ref_clk_i,               // 10 MHz clock
  input  wire logic           rst_i,                   // sync reset
  input  wire l2ct_cfg_t      cfg_i,                   // configuration
  input  wire logic           req_valid_i,             // request offered
  input  wire l2ct_req_t      req_i,                   // request fields
  output logic                req_ready_o,             // request taken
  output logic                done_o,                  // request finished
  output logic                hit_o,                   // lookup hit
  output logic                dirty_o,                 // resident modified
  output logic                mem_write_o,             // write to memory
  output logic                castout_o,               // victim pulse
  output logic [31:0]         castout_addr_o,          // victim address
  output logic                parity_check_o,          // check parity now
  output logic                parity_gen_o,            // generate parity
  output logic [IDX_W-1:0]    tag_index_o,             // tag ram address
  output logic [TAG_W-1:0]    tag_data_o,              // tag data out
  input  wire logic [TAG_W-1:0] tag_data_i,            // tag data in
  output logic                tag_data_oe_n_o,         // low: drive tag
  output logic                tag_valid_line_o,        // valid out
  output logic                tag_valid_line_oe_n_o,   // low: drive valid
  output logic                tag_modified_out_o,      // new modified
  input  wire logic           tag_match_i,             // tag compare
  input  wire logic           tag_modified_i,          // resident dirty
  output logic                tag_addr_output_en_n_o,  // tag addr drive
  output logic                tag_output_en_n_o,       // tag ram read
  output logic                tag_write_en_n_o,        // tag ram write
  output logic                tag_addr_latch_en_o,     // cs or bit 0
  output logic                burst_addr_strobe_n_o,   // burst start
  output logic                burst_advance_n_o,       // advance or bit 1
  output logic                data_ram_output_en_n_o,  // data ram read
  output logic [7:0]          data_ram_byte_write_n_o, // byte writes
  output logic                data_addr_latch_en_o,    // async addr latch
  output logic [DRA_W-1:0]    data_ram_addr_o          // data ram address
);

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  l2ct_state_t state_ff, nxt_state;
  l2ct_req_t   req_ff, nxt_req;
  logic [1:0]  beat_ff, nxt_beat;
  logic        xwr_ff, nxt_xwr;        // transfer writes the data ram
  logic        single_ff, nxt_single;  // one beat only
  logic        cast_ff, nxt_cast;      // transfer is the victim read
  logic        tagw_ff, nxt_tagw;      // tag write after transfer
  logic        newval_ff, nxt_newval;
  logic        newmod_ff, nxt_newmod;
  logic        done_ff, nxt_done;
  logic        hit_ff, nxt_hit;
  logic        dirty_ff, nxt_dirty;
  logic        memw_ff, nxt_memw;
  logic        co_ff, nxt_co;
  logic [31:0] coaddr_ff, nxt_coaddr;

  logic [TAG_W-1:0] map_tag;
  logic [31:0]      map_victim;
  logic             in_x, last, match, line_mod, hit_now, cacheable;
  logic             burst_addr_bit0, burst_addr_bit1;

  l2ct_addr_map u_map (
    .addr_i   (req_ff.addr),
    .size_i   (cfg_i.size),
    .mask_i   (cfg_i.mask),
    .tag_i    (tag_data_i),
    .index_o  (tag_index_o),
    .tag_o    (map_tag),
    .dram_o   (data_ram_addr_o),
    .victim_o (map_victim)
  );

  // ----------------------------------------------------------------
  // lookup status
  // ----------------------------------------------------------------
  // polarity folded in once so the sequencer sees active-high status
  assign match     = (tag_match_i == cfg_i.match_hi);
  assign line_mod  = (tag_modified_i == cfg_i.mod_hi)
                   & cfg_i.write_back;
  assign hit_now   = cfg_i.enable & tag_valid_line_o & match;
  // 8-bit rom cannot be cached on async sram; rom writes never are
  assign cacheable = cfg_i.enable
                   & ~(req_ff.rom & req_ff.rom8 & cfg_i.async_sram)
                   & ~(req_ff.rom & req_ff.write);
  assign in_x      = (state_ff == ST_XFER);
  assign last      = single_ff ? (beat_ff == BEAT_RST)
                               : (beat_ff == BEAT_LAST);

  // ----------------------------------------------------------------
  // sequencer next state
  // ----------------------------------------------------------------
  always_comb
  begin
    nxt_state  = state_ff;
    nxt_req    = req_ff;
    nxt_beat   = beat_ff;
    nxt_xwr    = xwr_ff;
    nxt_single = single_ff;
    nxt_cast   = cast_ff;
    nxt_tagw   = tagw_ff;
    nxt_newval = newval_ff;
    nxt_newmod = newmod_ff;
    nxt_done   = 1'b0;
    nxt_hit    = hit_ff;
    nxt_dirty  = dirty_ff;
    nxt_memw   = 1'b0;
    nxt_co     = 1'b0;
    nxt_coaddr = coaddr_ff;
    unique case (state_ff)
      ST_IDLE:
      begin
        if (req_valid_i)
        begin
          nxt_req   = req_i;
          nxt_state = ST_LOOK;
        end
      end
      ST_LOOK:
      begin
        // both tag enables are off here, so the tag ram compares
        nxt_hit    = hit_now;
        nxt_dirty  = hit_now & line_mod;
        nxt_beat   = BEAT_RST;
        nxt_single = ~req_ff.burst;
        nxt_cast   = 1'b0;
        nxt_newval = 1'b1;
        // rom lines are only ever cached write-through
        nxt_newmod = req_ff.write & cfg_i.write_back & ~req_ff.rom;
        nxt_state  = ST_IDLE;
        nxt_done   = 1'b1;
        if (req_ff.snoop)
          nxt_state = ST_IDLE;
        else if (req_ff.inval && cfg_i.enable)
        begin
          nxt_newval = 1'b0;
          nxt_newmod = 1'b0;
          nxt_state  = ST_TAGW;
          nxt_done   = 1'b0;
        end
        else if (!req_ff.write)
        begin
          if (hit_now)
          begin
            nxt_xwr   = 1'b0;
            nxt_tagw  = 1'b0;
            nxt_state = ST_XFER;
            nxt_done  = 1'b0;
          end
          else if (req_ff.burst && cacheable)
          begin
            nxt_xwr    = 1'b1;                    // line fill
            nxt_single = 1'b0;
            nxt_tagw   = 1'b1;
            nxt_state  = line_mod ? ST_CAST : ST_XFER;
            nxt_done   = 1'b0;
          end
        end
        else
        begin
          // write-through always forwards; write-back only uncached or single-beat misses
          nxt_memw = ~cfg_i.write_back | ~cacheable
                   | (~hit_now & ~req_ff.burst);
          if (cacheable && (hit_now || (req_ff.burst
                                        && cfg_i.write_back)))
          begin
            nxt_xwr   = 1'b1;
            nxt_tagw  = 1'b1;
            nxt_state = (!hit_now && line_mod) ? ST_CAST : ST_XFER;
            nxt_done  = 1'b0;
          end
        end
      end
      ST_CAST:
      begin
        // victim tag latched; its data is read out before the fill
        nxt_coaddr = map_victim;
        nxt_co     = 1'b1;
        nxt_cast   = 1'b1;
        nxt_xwr    = 1'b0;
        nxt_beat   = BEAT_RST;
        nxt_state  = ST_XFER;
      end
      ST_XFER:
      begin
        nxt_beat = beat_ff + 2'h1;
        if (last)
        begin
          nxt_beat = BEAT_RST;
          if (cast_ff)
          begin
            nxt_cast = 1'b0;
            nxt_xwr  = 1'b1;
          end
          else if (tagw_ff)
            nxt_state = ST_TAGW;
          else
          begin
            nxt_state = ST_IDLE;
            nxt_done  = 1'b1;
          end
        end
      end
      ST_TAGW:
      begin
        nxt_state = ST_IDLE;
        nxt_done  = 1'b1;
      end
      default:
        nxt_state = ST_IDLE;
    endcase
  end

  // sequencer registers
  always_ff @(posedge ref_clk_i)
  begin
    if (rst_i)
    begin
      state_ff  <= ST_RST;
      req_ff    <= '0;
      beat_ff   <= BEAT_RST;
      xwr_ff    <= 1'b0;
      single_ff <= 1'b0;
      cast_ff   <= 1'b0;
      tagw_ff   <= 1'b0;
      newval_ff <= 1'b0;
      newmod_ff <= 1'b0;
      done_ff   <= 1'b0;
      hit_ff    <= 1'b0;
      dirty_ff  <= 1'b0;
      memw_ff   <= 1'b0;
      co_ff     <= 1'b0;
      coaddr_ff <= 32'h0;
    end
    else
    begin
      state_ff  <= nxt_state;
      req_ff    <= nxt_req;
      beat_ff   <= nxt_beat;
      xwr_ff    <= nxt_xwr;
      single_ff <= nxt_single;
      cast_ff   <= nxt_cast;
      tagw_ff   <= nxt_tagw;
      newval_ff <= nxt_newval;
      newmod_ff <= nxt_newmod;
      done_ff   <= nxt_done;
      hit_ff    <= nxt_hit;
      dirty_ff  <= nxt_dirty;
      memw_ff   <= nxt_memw;
      co_ff     <= nxt_co;
      coaddr_ff <= nxt_coaddr;
    end
  end

  // ----------------------------------------------------------------
  // request side outputs
  // ----------------------------------------------------------------
  assign req_ready_o    = (state_ff == ST_IDLE);
  assign done_o         = done_ff;
  assign hit_o          = hit_ff;
  assign dirty_o        = dirty_ff;
  assign mem_write_o    = memw_ff;
  assign castout_o      = co_ff;
  assign castout_addr_o = coaddr_ff;
  // rom fills carry no good parity, so reads there go unchecked
  assign parity_check_o = cfg_i.par_en & in_x & ~xwr_ff
                        & ~req_ff.rom;
  assign parity_gen_o   = cfg_i.par_en & in_x & xwr_ff;

  // ----------------------------------------------------------------
  // tag ram pins
  // ----------------------------------------------------------------
  assign tag_write_en_n_o       = (state_ff != ST_TAGW);
  assign tag_output_en_n_o      = (state_ff != ST_CAST);
  assign tag_addr_output_en_n_o = (state_ff == ST_CAST);
  assign tag_data_oe_n_o        = (state_ff == ST_CAST);
  assign tag_data_o             = map_tag;
  // valid is an output only; tag rams may compare it on lookup
  assign tag_valid_line_o       = (state_ff == ST_TAGW) ? newval_ff
                                                        : 1'b1;
  assign tag_valid_line_oe_n_o  = (state_ff == ST_CAST)
                                | ~cfg_i.l2_present | cfg_i.two_cpu;
  assign tag_modified_out_o     = (newmod_ff & cfg_i.write_back)
                                == cfg_i.mod_hi;

  // ----------------------------------------------------------------
  // data ram pins
  // ----------------------------------------------------------------
  // async sram reuses the latch enable and advance pins as beat bits;
  // that mode relies on software choosing byte decode and mode 01
  assign burst_addr_bit0 = beat_ff[0];
  assign burst_addr_bit1 = beat_ff[1];

  always_comb
  begin
    if (cfg_i.async_sram)
    begin
      tag_addr_latch_en_o   = burst_addr_bit0;
      burst_advance_n_o     = burst_addr_bit1;
      burst_addr_strobe_n_o = 1'b1;
      data_addr_latch_en_o  = in_x & (beat_ff == BEAT_RST);
    end
    else
    begin
      // outside early write the chip select simply stays asserted
      tag_addr_latch_en_o   = (cfg_i.wmode == WMODE_EARLY) ? in_x
                                                           : 1'b1;
      burst_advance_n_o     = ~(in_x & (beat_ff != BEAT_RST));
      burst_addr_strobe_n_o = ~(in_x & (beat_ff == BEAT_RST));
      data_addr_latch_en_o  = 1'b0;
    end
    data_ram_output_en_n_o  = ~(in_x & ~xwr_ff);
    // lane decode only for single beats with on-chip decode
    if (in_x && xwr_ff)
      data_ram_byte_write_n_o = (single_ff && cfg_i.byte_dec)
                              ? ~req_ff.be : 8'h00;
    else
      data_ram_byte_write_n_o = 8'hff;
  end

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (rst_i);

  a_castout_tag_read: assert property (
    state_ff == ST_CAST |-> !tag_output_en_n_o && tag_addr_output_en_n_o
      && tag_data_oe_n_o && tag_valid_line_oe_n_o ##1 castout_o)
    else $error("cast-out tag read pins wrong");
  a_tag_write_set: assert property (
    !tag_write_en_n_o |-> !tag_data_oe_n_o && !tag_addr_output_en_n_o
      && tag_output_en_n_o ##1 tag_write_en_n_o)
    else $error("tag write not driving line status");
  a_lookup_valid_hi: assert property (
    state_ff == ST_LOOK |-> tag_valid_line_o)
    else $error("valid low during lookup");
  a_valid_floats: assert property (
    cfg_i.two_cpu || !cfg_i.l2_present |-> tag_valid_line_oe_n_o)
    else $error("valid driven without l2");
  a_dirty_castout: assert property (
    state_ff == ST_LOOK && !req_ff.write && !req_ff.snoop
      && !req_ff.inval && req_ff.burst && cacheable && !hit_now
      && line_mod |=> state_ff == ST_CAST ##1 state_ff == ST_XFER
      && !xwr_ff)
    else $error("dirty victim not cast out");
  a_wt_mem_write: assert property (
    state_ff == ST_LOOK && req_ff.write && !req_ff.snoop
      && !req_ff.inval && !cfg_i.write_back |=> mem_write_o)
    else $error("write-through write missed memory");
  a_disabled_miss: assert property (
    state_ff == ST_LOOK && !cfg_i.enable |=> !hit_o && done_o)
    else $error("disabled cache reported hit");
  a_burst_beats: assert property (
    !cfg_i.async_sram && $fell(burst_addr_strobe_n_o) && !single_ff
      |=> (!burst_advance_n_o && burst_addr_strobe_n_o)[*3]
      ##1 burst_advance_n_o)
    else $error("burst not four beats");
  a_rom_no_parity: assert property (
    req_ff.rom |-> !parity_check_o)
    else $error("parity checked on rom read");
  a_parity_gate: assert property (
    !cfg_i.par_en |-> !parity_check_o && !parity_gen_o)
    else $error("parity active while disabled");
  a_early_cs: assert property (
    !cfg_i.async_sram && cfg_i.wmode == WMODE_EARLY
      |-> tag_addr_latch_en_o == in_x)
    else $error("early write chip select wrong");

  c_castout: cover property (state_ff == ST_CAST ##1 castout_o);
  c_read_hit: cover property (
    state_ff == ST_LOOK && hit_now && !req_ff.write ##1 in_x);
  c_tag_write: cover property (!tag_write_en_n_o ##1 done_o);

endmodule
`default_nettype wire

// ---- rtl/l2ct_pkg.sv ----
// l2ct_pkg: constants and carriers for the level-2 cache tag/data ram
// interface. assumes a 32-bit processor address, bit 31 being A0.
package l2ct_pkg;

  // ----------------------------------------------------------------
  // cache geometry
  // ----------------------------------------------------------------
  localparam int         TAG_W     = 14;     // widest stored tag
  localparam int         IDX_W     = 15;     // widest tag index
  localparam int         DRA_W     = 17;     // widest data ram address
  localparam logic [4:0] LINE_LSB  = 5'd5;   // 32-byte line
  localparam logic [4:0] DRA_LSB   = 5'd3;   // 64-bit beat
  localparam logic [4:0] TLSB_256K = 5'd18;  // tag starts above A13
  localparam logic [4:0] TLSB_512K = 5'd19;  // tag starts above A12
  localparam logic [4:0] TLSB_1M   = 5'd20;  // tag starts above A11

  localparam logic [1:0] SIZE_256K = 2'h0;
  localparam logic [1:0] SIZE_512K = 2'h1;
  localparam logic [1:0] SIZE_1M   = 2'h2;

  // ----------------------------------------------------------------
  // write timing modes and burst
  // ----------------------------------------------------------------
  localparam logic [1:0] WMODE_ASYNC = 2'h1;  // needed for async sram
  localparam logic [1:0] WMODE_EARLY = 2'h2;  // early write timing
  localparam logic [1:0] BEAT_LAST   = 2'h3;  // four beats per burst
  localparam logic [1:0] BEAT_RST    = 2'h0;

  // ----------------------------------------------------------------
  // controller states, gray along idle-look-cast-xfer-tagw
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    ST_IDLE = 3'h0,
    ST_LOOK = 3'h1,
    ST_CAST = 3'h3,
    ST_XFER = 3'h2,
    ST_TAGW = 3'h6
  } l2ct_state_t;

  localparam l2ct_state_t ST_RST = ST_IDLE;

  // processor or snoop request
  typedef struct packed {
    logic [31:0] addr;   // byte address, bit 31 is A0
    logic        write;  // write, else read
    logic        burst;  // four-beat burst, else single beat
    logic        snoop;  // snoop lookup only
    logic        inval;  // invalidate line (invalidate mode)
    logic        rom;    // local rom address space
    logic        rom8;   // 8-bit rom
    logic [7:0]  be;     // byte lanes of a single beat
  } l2ct_req_t;

  // static configuration
  typedef struct packed {
    logic        enable;      // l2 cache enabled
    logic        write_back;  // write-back, else write-through
    logic [1:0]  size;        // SIZE_*
    logic [13:0] mask;        // castout_addr_mask, set bit drops tag bit
    logic        match_hi;    // tag match active high
    logic        mod_hi;      // modified status active high
    logic [1:0]  wmode;       // write_timing_mode_sel
    logic        byte_dec;    // onchip_byte_decode_sel
    logic        async_sram;  // asynchronous sram data ram
    logic        par_en;      // l2_parity_check_en
    logic        l2_present;  // single processor with l2 fitted
    logic        two_cpu;     // two processor mode
  } l2ct_cfg_t;

endpackage

// ---- tb/l2ct_tram.sv ----
// l2ct_tram: tag ram model with valid and dirty per line
// assumes lookup answers in the same cycle as the index
`timescale 1ns/100ps
`default_nettype none
module l2ct_tram
  import l2ct_pkg::*;
(
  input  wire logic             clk_i,  // clock
  input  wire logic             rst_i,  // clears lines
  input  wire l2ct_cfg_t        cfg_i,  // polarities
  input  wire logic [IDX_W-1:0] idx_i,  // index
  input  wire logic [TAG_W-1:0] tag_i,  // tag bus
  input  wire logic             v_i,    // valid line
  input  wire logic             m_i,    // modified out
  input  wire logic             oe_n_i, // tag read
  input  wire logic             we_n_i, // tag write
  output logic                  hit_o,  // match
  output logic                  m_o,    // modified
  output logic [TAG_W-1:0]      tag_o   // tag read data
);
  // ------------------------------------------------------------
  // storage: valid, dirty, tag
  // ------------------------------------------------------------
  logic [TAG_W+1:0] mem [0:32767];
  logic [TAG_W+1:0] e;
  // reset leaves every line invalid and clean
  always @(posedge clk_i)
    if (rst_i)
      foreach (mem[i]) mem[i] = '0;
    else if (!we_n_i)
      mem[idx_i] = {v_i, m_i ~^ cfg_i.mod_hi, tag_i};
  assign e = mem[idx_i];
  // compare uses the valid input, not the stored bit alone
  assign hit_o = (e[TAG_W+1] & v_i & (e[TAG_W-1:0] == tag_i))
                 ~^ cfg_i.match_hi;
  assign m_o = e[TAG_W] ~^ cfg_i.mod_hi;
  // idle bus shows inverted data so a stale value never passes
  assign tag_o = oe_n_i ? ~e[TAG_W-1:0] : e[TAG_W-1:0];
endmodule
`default_nettype wire

// ---- tb/tb.sv ----
// tb: self-checking bench for l2ct_ctrl with a tag ram model
// assumes data ram needs no model for the checks made here
`timescale 1ns/100ps
`default_nettype none
module tb
  import l2ct_pkg::*;
;
  l2ct_cfg_t cfg_i;
  l2ct_req_t req_i;
  logic ref_clk_i = 0, rst_i = 1, req_valid_i = 0, co, mw;
  logic req_ready_o, done_o, hit_o, dirty_o, mem_write_o, castout_o;
  logic tag_data_oe_n_o, tag_valid_line_o, tag_valid_line_oe_n_o;
  logic tag_modified_out_o, tag_match_i, tag_modified_i;
  logic tag_output_en_n_o, tag_write_en_n_o;
  logic parity_check_o, burst_addr_strobe_n_o, data_addr_latch_en_o, pc;
  logic [DRA_W-1:0] data_ram_addr_o;
  logic [31:0] castout_addr_o, a;
  logic [IDX_W-1:0] tag_index_o;
  logic [TAG_W-1:0] tag_data_o, tag_data_i, ram_tag;
  int mismatches = 0, checks_done = 0, n, sb, dl;
  l2ct_ctrl u_dut (.ref_clk_i, .rst_i, .cfg_i, .req_valid_i, .req_i,
    .req_ready_o, .done_o, .hit_o, .dirty_o, .mem_write_o, .castout_o,
    .castout_addr_o, .parity_check_o, .parity_gen_o(), .tag_index_o,
    .tag_data_o, .tag_data_i, .tag_data_oe_n_o, .tag_valid_line_o,
    .tag_valid_line_oe_n_o, .tag_modified_out_o, .tag_match_i,
    .tag_modified_i, .tag_addr_output_en_n_o(), .tag_output_en_n_o,
    .tag_write_en_n_o, .tag_addr_latch_en_o(), .burst_addr_strobe_n_o,
    .burst_advance_n_o(), .data_ram_output_en_n_o(),
    .data_ram_byte_write_n_o(), .data_addr_latch_en_o,
    .data_ram_addr_o);
  l2ct_tram u_tram (.clk_i(ref_clk_i), .rst_i, .cfg_i, .idx_i(tag_index_o),
    .tag_i(tag_data_i), .v_i(tag_valid_line_o & !tag_valid_line_oe_n_o),
    .m_i(tag_modified_out_o), .oe_n_i(tag_output_en_n_o),
    .we_n_i(tag_write_en_n_o), .hit_o(tag_match_i),
    .m_o(tag_modified_i), .tag_o(ram_tag));
  // shared tag bus: whoever enables drives it
  assign tag_data_i = tag_data_oe_n_o ? ram_tag : tag_data_o;
  always #50 ref_clk_i = !ref_clk_i;
  // ------------------------------------------------------------
  // tasks
  // ------------------------------------------------------------
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp)
    begin
      mismatches++;
      $display("[FAIL] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic finish_test;
    $display("checks %0d mismatches %0d", checks_done, mismatches);
    if (mismatches == 0 && checks_done > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  task automatic reset;
    rst_i <= 1;
    repeat (6) @(posedge ref_clk_i);
    rst_i <= 0;
  endtask
  // one request; the take cycle counts as one, so n is the done cycle
  // f holds snoop, inval, rom, rom8; strobes and latches are counted
  task automatic req(input logic [31:0] ad, input logic w, b,
                     input logic [3:0] f = 4'h0);
    @(posedge ref_clk_i);
    req_i <= '{addr: ad, write: w, burst: b, snoop: f[3], inval: f[2],
               rom: f[1], rom8: f[0], default: '0};
    req_valid_i <= 1;
    @(posedge ref_clk_i);
    req_valid_i <= 0;
    n = 1;
    co = 0;
    mw = 0;
    pc = 0;
    sb = 0;
    dl = 0;
    do
    begin
      @(posedge ref_clk_i);
      #1;
      n++;
      co |= castout_o;
      mw |= mem_write_o;
      pc |= parity_check_o;
      sb += !burst_addr_strobe_n_o;
      dl += data_addr_latch_en_o;
    end
    while (done_o !== 1'b1 && n < 30);
  endtask
  // ------------------------------------------------------------
  // main sequence
  // ------------------------------------------------------------
  initial
  begin
    void'($urandom(50480));
    cfg_i = '0;
    req_i = '0;
    reset;
    req($urandom & 32'hffff_ffe0, 0, 1);
    chk(n, 2);
    chk(hit_o, 0);
    // every size, random polarities; flips at index top and tag bottom
    for (int s = 0; s < 3; s++)
    begin
      a = $urandom & 32'hffff_ffe0;
      @(posedge ref_clk_i);
      cfg_i <= '{enable: 1'b1, write_back: 1'b1, size: 2'(s),
        match_hi: 1'($urandom), mod_hi: 1'($urandom), l2_present: 1'b1,
        default: '0};
      reset;
      req(a, 0, 1);
      chk(n, 7);
      req(a, 0, 1);
      chk(n, 6);
      chk(sb, 1);
      chk(hit_o, 1);
      chk(data_ram_addr_o, (a >> 3) & ((32'h1 << (15 + s)) - 1));
      req(a, 1, 1);
      chk(mw, 0);
      req(a, 0, 0);
      chk(n, 3);
      chk(dirty_o, 1);
      req(a ^ (32'h1 << (17 + s)), 0, 1);
      chk(co, 0);
      req(a ^ (32'h1 << (18 + s)), 0, 1);
      chk(n, 12);
      chk(co, 1);
      chk(castout_addr_o, a);
      chk(sb, 2);
    end
    @(posedge ref_clk_i);
    cfg_i.write_back <= 0;
    cfg_i.wmode <= WMODE_EARLY;
    req(a, 1, 0);
    chk(mw, 1);
    // async sram with parity: rom8 stays uncached, rom reads skip parity
    a ^= 32'h40;
    @(posedge ref_clk_i);
    cfg_i.async_sram <= 1;
    cfg_i.par_en <= 1;
    cfg_i.byte_dec <= 1;
    cfg_i.wmode <= WMODE_ASYNC;
    req(a, 0, 1, 4'h3);
    chk(n, 2);
    req(a, 0, 1, 4'h2);
    chk(n, 7);
    chk(dl, 1);
    req(a, 0, 1, 4'h2);
    chk(pc, 0);
    req(a, 0, 1);
    chk(pc, 1);
    req(a, 0, 0, 4'h8);
    chk(n, 2);
    chk(hit_o, 1);
    req(a, 0, 0, 4'h4);
    chk(n, 3);
    req(a, 0, 0, 4'h8);
    chk(hit_o, 0);
    chk(tag_valid_line_oe_n_o, 0);
    @(posedge ref_clk_i);
    cfg_i.two_cpu <= 1;
    repeat (2) @(posedge ref_clk_i);
    #1;
    chk(tag_valid_line_oe_n_o, 1);
    finish_test;
  end
  // tests need well under a thousand cycles; this allows ten thousand
  initial
  begin
    #1000000;
    mismatches++;
    finish_test;
  end
endmodule
`default_nettype wire
